// ---- rtl/bsel_defs.vh ----
// boot source selector constants
`ifndef BSEL_DEFS_VH
`define BSEL_DEFS_VH
// boot source codes (output encoding)
`define BSEL_SRC_FIRST_UART    4'h0
`define BSEL_SRC_QUAD_FLASH    4'h1
`define BSEL_SRC_STATIC_8      4'h2
`define BSEL_SRC_STATIC_16     4'h3
`define BSEL_SRC_STATIC_32     4'h4
`define BSEL_SRC_USB_ZERO      4'h5
`define BSEL_SRC_USB_ONE       4'h6
`define BSEL_SRC_SYNC_SPI      4'h7
`define BSEL_SRC_SECOND_USART  4'h8
`define BSEL_SRC_NONE          4'hF
// programmed field codes
`define BSEL_OTP_STATIC_16     4'h4
`define BSEL_OTP_STATIC_32     4'h5
`define BSEL_OTP_USB_ZERO      4'h6
`define BSEL_OTP_USB_ONE       4'h7
`define BSEL_OTP_SYNC_SPI      4'h8
`define BSEL_OTP_SECOND_USART  4'h9
// pin function codes
`define BSEL_FN_DEFAULT        3'h0
`define BSEL_FN_QUAD_FLASH     3'h3
`define BSEL_FN_SYNC_PORT      3'h2
`define BSEL_FN_UART           3'h1
// edges counted before capture, lets the synchroniser fill
`define BSEL_CAPTURE_WAIT      2'h2
// static data bus width codes
`define BSEL_WIDTH_8           2'h0
`define BSEL_WIDTH_16          2'h1
`define BSEL_WIDTH_32          2'h2
`endif

// ---- rtl/bsel_decode.v ----
// boot code decoder: otp field or straps to source
`timescale 1ns/100ps
`default_nettype none
`include "bsel_defs.vh"
module bsel_decode (
    // inputs
    input  wire [3:0] otp_code,
    input  wire [3:0] strap_code,
    // result
    output reg  [3:0] src,
    output reg        valid
);
    always @* begin
        src   = `BSEL_SRC_NONE;
        valid = 1'b0;
        if (otp_code == 4'h0) begin
            valid = (strap_code <= 4'h8);
            if (strap_code <= 4'h8) begin
                src = strap_code;
            end
        end else begin
            valid = 1'b1;
            case (otp_code)
                `BSEL_OTP_STATIC_16:    src = `BSEL_SRC_STATIC_16;
                `BSEL_OTP_STATIC_32:    src = `BSEL_SRC_STATIC_32;
                `BSEL_OTP_USB_ZERO:     src = `BSEL_SRC_USB_ZERO;
                `BSEL_OTP_USB_ONE:      src = `BSEL_SRC_USB_ONE;
                `BSEL_OTP_SYNC_SPI:     src = `BSEL_SRC_SYNC_SPI;
                `BSEL_OTP_SECOND_USART: src = `BSEL_SRC_SECOND_USART;
                default: begin
                    src   = `BSEL_SRC_NONE;
                    valid = 1'b0;
                end
            endcase
        end
    end
endmodule // bsel_decode
`default_nettype wire

// ---- rtl/bsel_top.v ----
// boot source selector: latch selection, drive pin functions
// Behaviour
// - zero field selects source from four straps
// - programmed field codes 4-9 select boot source
// - straps 0000 select first uart pins
// - straps 0001 select quad flash boot
// - straps 0010-0100 select static memory widths
// - sync port spi flash on port3 pins 3,6,7,8
// - second usart on port2 pins 3,4
// - pin muxing set for serial flash source
// - quad and sync port functions differ
`timescale 1ns/100ps
`default_nettype none
`include "bsel_defs.vh"
module bsel_top (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    // boot field
    input  wire [3:0] otp_boot_source_field,
    // strap pins
    input  wire       strap_bit3_pin,
    input  wire       strap_bit2_pin,
    input  wire       strap_bit1_pin,
    input  wire       strap_bit0_pin,
    // selection
    output reg  [3:0] otp_boot_source_field_q,
    output reg        boot_valid_q,
    output reg        boot_done_q,
    output reg        static_chip_select_zero_en_q,
    output reg  [1:0] static_width_q,
    // pin functions: port3 pins 3..8, port2 pins 0,1,3,4
    output reg  [2:0] p3_3_fn_q,
    output reg  [2:0] p3_4_fn_q,
    output reg  [2:0] p3_5_fn_q,
    output reg  [2:0] p3_6_fn_q,
    output reg  [2:0] p3_7_fn_q,
    output reg  [2:0] p3_8_fn_q,
    output reg  [2:0] p2_0_fn_q,
    output reg  [2:0] p2_1_fn_q,
    output reg  [2:0] p2_3_fn_q,
    output reg  [2:0] p2_4_fn_q
);
    // synchroniser stages
    reg  [3:0] strap_meta_q;
    reg  [3:0] strap_sync_q;
    // capture state
    reg  [1:0] wait_q;
    reg  [1:0] wait_d;
    reg        boot_done_d;
    reg  [3:0] otp_boot_source_field_d;
    reg        boot_valid_d;
    // decoder result
    wire [3:0] dec_src;
    wire       dec_valid;
    // next pin functions
    reg  [2:0] p3_3_fn_d;
    reg  [2:0] p3_4_fn_d;
    reg  [2:0] p3_5_fn_d;
    reg  [2:0] p3_6_fn_d;
    reg  [2:0] p3_7_fn_d;
    reg  [2:0] p3_8_fn_d;
    reg  [2:0] p2_0_fn_d;
    reg  [2:0] p2_1_fn_d;
    reg  [2:0] p2_3_fn_d;
    reg  [2:0] p2_4_fn_d;
    // next static memory setup
    reg        static_chip_select_zero_en_d;
    reg  [1:0] static_width_d;

    // static memory sources share chip select zero
    function is_static_src;
        input [3:0] src;
        begin
            is_static_src = (src == `BSEL_SRC_STATIC_8)  ||
                            (src == `BSEL_SRC_STATIC_16) ||
                            (src == `BSEL_SRC_STATIC_32);
        end
    endfunction

    // data bus width code of a static source
    function [1:0] static_width_of;
        input [3:0] src;
        begin
            case (src)
                `BSEL_SRC_STATIC_16: static_width_of = `BSEL_WIDTH_16;
                `BSEL_SRC_STATIC_32: static_width_of = `BSEL_WIDTH_32;
                default:             static_width_of = `BSEL_WIDTH_8;
            endcase
        end
    endfunction

    // port3 function; sync port leaves pins 4 and 5 alone
    function [2:0] port3_fn;
        input [3:0] src;
        input       sync_pin;
        begin
            case (src)
                `BSEL_SRC_QUAD_FLASH: begin
                    port3_fn = `BSEL_FN_QUAD_FLASH;
                end
                `BSEL_SRC_SYNC_SPI: begin
                    if (sync_pin) begin
                        port3_fn = `BSEL_FN_SYNC_PORT;
                    end else begin
                        port3_fn = `BSEL_FN_DEFAULT;
                    end
                end
                default: begin
                    port3_fn = `BSEL_FN_DEFAULT;
                end
            endcase
        end
    endfunction

    // port2 function: uart pins only for their own source
    function [2:0] port2_fn;
        input [3:0] src;
        input [3:0] owner;
        begin
            if (src == owner) begin
                port2_fn = `BSEL_FN_UART;
            end else begin
                port2_fn = `BSEL_FN_DEFAULT;
            end
        end
    endfunction

    // two-stage strap synchroniser
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            strap_meta_q <= 4'h0;
            strap_sync_q <= 4'h0;
        end else begin
            strap_meta_q <= {strap_bit3_pin, strap_bit2_pin,
                             strap_bit1_pin, strap_bit0_pin};
            strap_sync_q <= strap_meta_q;
        end
    end

    bsel_decode u_dec (
        .otp_code   (otp_boot_source_field),
        .strap_code (strap_sync_q),
        .src        (dec_src),
        .valid      (dec_valid)
    );

    // capture once the synchroniser has filled
    always @* begin
        wait_d       = wait_q;
        boot_done_d  = boot_done_q;
        otp_boot_source_field_d   = otp_boot_source_field_q;
        boot_valid_d = boot_valid_q;
        if (!boot_done_q) begin
            if (wait_q == `BSEL_CAPTURE_WAIT) begin
                boot_done_d  = 1'b1;
                otp_boot_source_field_d   = dec_src;
                boot_valid_d = dec_valid;
            end else begin
                wait_d = wait_q + 2'h1;
            end
        end
    end

    // selection registers
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            wait_q       <= 2'h0;
            boot_done_q  <= 1'b0;
            otp_boot_source_field_q   <= `BSEL_SRC_NONE;
            boot_valid_q <= 1'b0;
        end else begin
            wait_q       <= wait_d;
            boot_done_q  <= boot_done_d;
            otp_boot_source_field_q   <= otp_boot_source_field_d;
            boot_valid_q <= boot_valid_d;
        end
    end

    // next pin functions from the held selection
    always @* begin
        p3_3_fn_d = p3_3_fn_q;
        p3_4_fn_d = p3_4_fn_q;
        p3_5_fn_d = p3_5_fn_q;
        p3_6_fn_d = p3_6_fn_q;
        p3_7_fn_d = p3_7_fn_q;
        p3_8_fn_d = p3_8_fn_q;
        p2_0_fn_d = p2_0_fn_q;
        p2_1_fn_d = p2_1_fn_q;
        p2_3_fn_d = p2_3_fn_q;
        p2_4_fn_d = p2_4_fn_q;
        static_chip_select_zero_en_d = static_chip_select_zero_en_q;
        static_width_d               = static_width_q;
        if (boot_done_q) begin
            p3_3_fn_d = port3_fn(otp_boot_source_field_q, 1'b1);
            p3_4_fn_d = port3_fn(otp_boot_source_field_q, 1'b0);
            p3_5_fn_d = port3_fn(otp_boot_source_field_q, 1'b0);
            p3_6_fn_d = port3_fn(otp_boot_source_field_q, 1'b1);
            p3_7_fn_d = port3_fn(otp_boot_source_field_q, 1'b1);
            p3_8_fn_d = port3_fn(otp_boot_source_field_q, 1'b1);
            p2_0_fn_d = port2_fn(otp_boot_source_field_q, `BSEL_SRC_FIRST_UART);
            p2_1_fn_d = port2_fn(otp_boot_source_field_q, `BSEL_SRC_FIRST_UART);
            p2_3_fn_d = port2_fn(otp_boot_source_field_q, `BSEL_SRC_SECOND_USART);
            p2_4_fn_d = port2_fn(otp_boot_source_field_q, `BSEL_SRC_SECOND_USART);
            static_chip_select_zero_en_d = is_static_src(otp_boot_source_field_q);
            static_width_d = static_width_of(otp_boot_source_field_q);
        end
    end

    // pin function registers
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            p3_3_fn_q <= `BSEL_FN_DEFAULT;
            p3_4_fn_q <= `BSEL_FN_DEFAULT;
            p3_5_fn_q <= `BSEL_FN_DEFAULT;
            p3_6_fn_q <= `BSEL_FN_DEFAULT;
            p3_7_fn_q <= `BSEL_FN_DEFAULT;
            p3_8_fn_q <= `BSEL_FN_DEFAULT;
            p2_0_fn_q <= `BSEL_FN_DEFAULT;
            p2_1_fn_q <= `BSEL_FN_DEFAULT;
            p2_3_fn_q <= `BSEL_FN_DEFAULT;
            p2_4_fn_q <= `BSEL_FN_DEFAULT;
            static_chip_select_zero_en_q <= 1'b0;
            static_width_q               <= `BSEL_WIDTH_8;
        end else begin
            p3_3_fn_q <= p3_3_fn_d;
            p3_4_fn_q <= p3_4_fn_d;
            p3_5_fn_q <= p3_5_fn_d;
            p3_6_fn_q <= p3_6_fn_d;
            p3_7_fn_q <= p3_7_fn_d;
            p3_8_fn_q <= p3_8_fn_d;
            p2_0_fn_q <= p2_0_fn_d;
            p2_1_fn_q <= p2_1_fn_d;
            p2_3_fn_q <= p2_3_fn_d;
            p2_4_fn_q <= p2_4_fn_d;
            static_chip_select_zero_en_q <= static_chip_select_zero_en_d;
            static_width_q               <= static_width_d;
        end
    end
endmodule // bsel_top
`default_nettype wire

// ---- verification/bsel_strap_model.sv ----
// strap resistor model for the four boot straps
`timescale 1ns/100ps
`default_nettype none
module bsel_strap_model (
    // strap code from bench
    input  wire logic [3:0] code,
    // strap pins, bit 3 first
    output wire logic [3:0] pins
);
    assign pins = code;
endmodule // bsel_strap_model
`default_nettype wire

// ---- verification/bsel_monitor.sv ----
// checker: boot selection timing and pin functions
`timescale 1ns/100ps
`default_nettype none
module bsel_monitor (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_b,
    // selection
    input wire logic       boot_valid_q,
    input wire logic       boot_done_q,
    input wire logic [3:0] otp_boot_source_field_q,
    // static memory
    input wire logic       static_chip_select_zero_en_q,
    input wire logic [1:0] static_width_q,
    // pin functions
    input wire logic [2:0] p3_3_fn_q,
    input wire logic [2:0] p3_4_fn_q,
    input wire logic [2:0] p3_5_fn_q,
    input wire logic [2:0] p3_6_fn_q,
    input wire logic [2:0] p3_7_fn_q,
    input wire logic [2:0] p3_8_fn_q,
    input wire logic [2:0] p2_0_fn_q,
    input wire logic [2:0] p2_1_fn_q,
    input wire logic [2:0] p2_3_fn_q,
    input wire logic [2:0] p2_4_fn_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_done_late: assert property (
        $rose(rst_b) |-> !boot_done_q [*3] ##1 boot_done_q)
        else $error("done timing");
    a_done_hold: assert property (boot_done_q |=> boot_done_q)
        else $error("done dropped");
    a_src_hold: assert property (boot_done_q |=> $stable(otp_boot_source_field_q)
        && $stable(boot_valid_q)) else $error("selection moved");
    a_quad_pins: assert property (
        $rose(boot_done_q) && otp_boot_source_field_q == 4'h1 |=>
        {p3_3_fn_q, p3_4_fn_q, p3_5_fn_q, p3_6_fn_q, p3_7_fn_q,
        p3_8_fn_q} == {6{3'h3}}) else $error("quad pins");
    a_spi_pins: assert property (
        $rose(boot_done_q) && otp_boot_source_field_q == 4'h7 |=>
        {p3_3_fn_q, p3_6_fn_q, p3_7_fn_q, p3_8_fn_q} == {4{3'h2}})
        else $error("spi pins");
    a_spi_spare: assert property (
        $rose(boot_done_q) && otp_boot_source_field_q == 4'h7 |=>
        {p3_4_fn_q, p3_5_fn_q} == 6'h0) else $error("spi spare pins");
    a_uart_pins: assert property (
        $rose(boot_done_q) && otp_boot_source_field_q == 4'h0 |=>
        {p2_0_fn_q, p2_1_fn_q} == {2{3'h1}}) else $error("uart pins");
    a_usart_pins: assert property (
        $rose(boot_done_q) && otp_boot_source_field_q == 4'h8 |=>
        {p2_3_fn_q, p2_4_fn_q} == {2{3'h1}}) else $error("usart pins");
    a_invalid_src: assert property (
        $rose(boot_done_q) && !boot_valid_q |-> otp_boot_source_field_q == 4'hF)
        else $error("invalid source code");
    a_invalid_quiet: assert property (
        $rose(boot_done_q) && !boot_valid_q |=>
        !static_chip_select_zero_en_q && {p3_3_fn_q, p3_4_fn_q,
        p3_5_fn_q, p3_6_fn_q, p3_7_fn_q, p3_8_fn_q, p2_0_fn_q,
        p2_1_fn_q, p2_3_fn_q, p2_4_fn_q} == 30'h0)
        else $error("invalid source set pins");
    a_static_width: assert property ($rose(boot_done_q) &&
        otp_boot_source_field_q inside {[2:4]} |=> static_chip_select_zero_en_q &&
        static_width_q == otp_boot_source_field_q[1:0] - 2'h2) else $error("static width");
endmodule // bsel_monitor
bind bsel_top bsel_monitor mon (
    .sys_clk                      (sys_clk),
    .rst_b                        (rst_b),
    .boot_valid_q                 (boot_valid_q),
    .boot_done_q                  (boot_done_q),
    .otp_boot_source_field_q                   (otp_boot_source_field_q),
    .static_chip_select_zero_en_q (static_chip_select_zero_en_q),
    .static_width_q               (static_width_q),
    .p3_3_fn_q                    (p3_3_fn_q),
    .p3_4_fn_q                    (p3_4_fn_q),
    .p3_5_fn_q                    (p3_5_fn_q),
    .p3_6_fn_q                    (p3_6_fn_q),
    .p3_7_fn_q                    (p3_7_fn_q),
    .p3_8_fn_q                    (p3_8_fn_q),
    .p2_0_fn_q                    (p2_0_fn_q),
    .p2_1_fn_q                    (p2_1_fn_q),
    .p2_3_fn_q                    (p2_3_fn_q),
    .p2_4_fn_q                    (p2_4_fn_q)
);
`default_nettype wire

// ---- verification/boot_source_selector_bench.sv ----
// bench: boot source selection over straps and field
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module boot_source_selector_bench;
    logic       sys_clk = 0, rst_b = 0;
    logic [3:0] otp_q = 4'h0, code_q = 4'h0;
    wire  [3:0] pins, src;
    wire        done, valid, cs0;
    wire  [1:0] width;
    wire  [2:0] f33, f34, f35, f36, f37, f38, f20, f21, f23, f24;
    int         err_total = 0, checks_done = 0, cyc = 0;
    always #10 sys_clk = ~sys_clk;
    bsel_strap_model model (.code(code_q), .pins(pins));
    bsel_top dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .otp_boot_source_field(otp_q), .strap_bit3_pin(pins[3]),
        .strap_bit2_pin(pins[2]), .strap_bit1_pin(pins[1]),
        .strap_bit0_pin(pins[0]), .otp_boot_source_field_q(src), .boot_valid_q(valid),
        .boot_done_q(done), .static_chip_select_zero_en_q(cs0),
        .static_width_q(width), .p3_3_fn_q(f33), .p3_4_fn_q(f34),
        .p3_5_fn_q(f35), .p3_6_fn_q(f36), .p3_7_fn_q(f37), .p3_8_fn_q(f38),
        .p2_0_fn_q(f20), .p2_1_fn_q(f21), .p2_3_fn_q(f23), .p2_4_fn_q(f24));
    task automatic boot(input logic [3:0] o, input logic [3:0] c);
        otp_q = o;
        code_q = c;
        rst_b = 0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1;
        repeat (6) @(negedge sys_clk);
    endtask
    task t_straps;
        for (int c = 0; c < 16; c++) begin
            boot(4'h0, c[3:0]);
            `CHK(src, (c < 9) ? c[3:0] : 4'hF)
            `CHK(valid, c < 9)
            `CHK(done, 1'b1)
        end
    endtask
    task t_otp;
        for (int o = 1; o < 16; o++) begin
            boot(o[3:0], 4'h0);
            `CHK(src, (o > 3 && o < 10) ? o[3:0] - 4'h1 : 4'hF)
            `CHK(valid, o > 3 && o < 10)
        end
    endtask
    task t_pins;
        boot(4'h0, 4'h1);
        `CHK({f33, f34, f35, f36, f37, f38}, {6{3'h3}})
        boot(4'h0, 4'h7);
        `CHK({f33, f36, f37, f38}, {4{3'h2}})
        `CHK({f34, f35}, 6'h0)
        boot(4'h8, 4'h0);
        `CHK({f33, f36, f37, f38}, {4{3'h2}})
        boot(4'h0, 4'h0);
        `CHK({f20, f21}, {2{3'h1}})
        boot(4'h0, 4'h8);
        `CHK({f23, f24}, {2{3'h1}})
        boot(4'h9, 4'h0);
        `CHK({f23, f24}, {2{3'h1}})
        boot(4'h0, 4'h2);
        `CHK({cs0, width}, 3'h4)
        boot(4'h0, 4'h3);
        `CHK({cs0, width}, 3'h5)
        boot(4'h0, 4'h4);
        `CHK({cs0, width}, 3'h6)
        boot(4'h0, 4'h5);
        `CHK({cs0, f33, f20, f23}, 10'h0)
    endtask
    task t_hold;
        boot(4'h0, 4'h5);
        code_q = 4'h6;
        otp_q = 4'h9;
        repeat (8) @(negedge sys_clk);
        `CHK({done, src}, 5'h15)
    endtask
    task results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        t_straps;
        t_otp;
        t_pins;
        t_hold;
        results;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            results;
        end
    end
endmodule // boot_source_selector_bench
`default_nettype wire
